// ==== ber_bus_model.sv ====
// far side model: bus clocks and error pins of both bridge sides
module ber_bus_model (
  // frame request; kind 0 secondary system error, 1 parity on both sides
  input  wire logic req,
  input  wire logic kind,
  output logic      busy,
  // bus clocks stand still between frames
  output logic      pclk,
  output logic      sclk,
  // pins fall back to their pull-ups when released
  output logic      ppar_n,
  output logic      spar_n,
  output logic      sserr_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {busy, pclk, sclk, ppar_n, spar_n, sserr_n} = 6'h07;
  // four bus cycles; offset keeps bus edges clear of block clock edges
  always @(posedge req) begin
    busy = 1'h1;
    #7;
    for (int i = 0; i < 4; i++) begin
      {ppar_n, spar_n, sserr_n} = (i == 1) ? (kind ? 3'h1 : 3'h6) : 3'h7;
      #100 {pclk, sclk} = 2'h3;
      #100 {pclk, sclk} = 2'h0;
    end
    busy = 1'h0;
  end
endmodule

// ==== ber_error_report.sv ====
// parity and system error reporting logic with axi4-lite control registers
module ber_error_report #(
  parameter int ADDR_W      = 8,
  parameter int RETRY_LIMIT = ber_pkg::RETRY_LIMIT_DEF
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // bus clocks of both sides, sampled as plain inputs
  input  wire logic              upstream_side_clk,
  input  wire logic              downstream_side_clk,
  // error pins of the upstream side
  input  wire logic              upstream_side_parity_err_n,
  output logic                   upstream_side_system_err_n_out,
  output logic                   upstream_side_system_err_n_oe_n,
  // error pins of the downstream side
  input  wire logic              downstream_side_parity_err_n_in,
  output logic                   downstream_side_parity_err_n_out,
  output logic                   downstream_side_parity_err_n_oe_n,
  input  wire logic              downstream_side_system_err_n,
  // secondary parity detection from the bus engine
  input  wire logic              sec_data_parity_err,
  input  wire logic              sec_write_target,
  input  wire logic              sec_read_initiator,
  input  wire logic              up_dw_completion,
  // forwarded posted write data phase on the target bus
  input  wire logic              pw_down_active,
  input  wire logic              pw_up_active,
  input  wire logic              pw_self_detected,
  // abort and timeout events from the bus engine
  input  wire logic              pw_target_abort,
  input  wire logic              pw_master_abort,
  input  wire logic              dt_master_timeout,
  // retry accounting: 0 posted write, 1 delayed write, 2 delayed read
  input  wire logic [2:0]        retry_rcvd,
  input  wire logic [2:0]        delivered,
  output logic [2:0]             retry_discard,
  // lock requests per side and for a crossing lock
  input  wire logic              pri_lock_set,
  input  wire logic              pri_lock_clr,
  input  wire logic              sec_lock_set,
  input  wire logic              sec_lock_clr,
  input  wire logic              cross_lock_set,
  input  wire logic              cross_lock_clr,
  output logic                   pri_lock_held,
  output logic                   sec_lock_held,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int RW = $clog2(RETRY_LIMIT + 1);
  localparam logic [RW-1:0] RETRY_LAST = RW'(RETRY_LIMIT - 1);
  localparam logic [3:0]    LINK_CNT   = 4'(ber_pkg::LINK_CYC);

  typedef struct packed {
    logic [4:0]              sync1;
    logic [4:0]              sync2;
    logic [1:0]              lclk_prev;
    logic                    pperr_smp;
    logic                    sperr_smp;
    logic                    sserr_smp;
    logic [1:0]              cmd;
    logic                    sig_serr;
    logic [2:0]              bctl;
    logic                    rcv_serr;
    logic [7:0]              cause;
    logic [7:0]              evdis;
    logic [2:0][RW-1:0]      retry_cnt;
    logic [2:0]              discard;
    logic [3:0]              serr_cnt;
    logic                    serr_oe_n;
    ber_pkg::ber_pe_state_t  pe_state;
    logic [3:0]              pe_cnt;
    logic                    pe_out;
    logic                    pe_oe_n;
    logic                    pri_lock;
    logic                    sec_lock;
    logic                    cross_lock;
    logic                    pri_held;
    logic                    sec_held;
    logic                    awready;
    logic                    aw_have;
    logic [ADDR_W-1:0]       aw_addr;
    logic                    wready;
    logic                    w_have;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } ber_state_t;

  ber_state_t st_reg;
  ber_state_t st_next;

  // bus clock edges and pin samples taken on them
  logic       pclk_rise;
  logic       sclk_rise;
  logic       sserr_event;
  logic       pperr_fall;
  logic       sperr_fall;
  logic [2:0] retry_hit;
  logic [7:0] ev_raw;
  logic [7:0] ev_qual;
  logic       perr_trig;
  logic       wr_fire;
  logic       clr_cause;

  assign pclk_rise = st_reg.sync2[ber_pkg::PIN_PCLK] & ~st_reg.lclk_prev[0];
  assign sclk_rise = st_reg.sync2[ber_pkg::PIN_SCLK] & ~st_reg.lclk_prev[1];
  // pins are sampled at their own bus clock edge, as the bus would see them
  assign sserr_event = sclk_rise & ~st_reg.sync2[ber_pkg::PIN_SSERR] & st_reg.sserr_smp;
  assign pperr_fall  = pclk_rise & ~st_reg.sync2[ber_pkg::PIN_PPERR] & st_reg.pperr_smp;
  assign sperr_fall  = sclk_rise & ~st_reg.sync2[ber_pkg::PIN_SPERR] & st_reg.sperr_smp;

  // retry limit reached on the retry that would pass the last count
  generate
    for (genvar g = 0; g < 3; g++) begin : g_retry
      assign retry_hit[g] = retry_rcvd[g] & ~delivered[g] & (st_reg.retry_cnt[g] == RETRY_LAST);
    end
  endgenerate

  // raw events; self-detected target parity never counts
  always_comb begin
    ev_raw = 8'h00;
    ev_raw[ber_pkg::EV_PARITY] = ~pw_self_detected &
      ((pw_down_active & sperr_fall) |
       (pw_up_active & pperr_fall));
    ev_raw[ber_pkg::EV_FORWARD]  = sserr_event;
    ev_raw[ber_pkg::EV_TABORT]   = pw_target_abort;
    ev_raw[ber_pkg::EV_MABORT]   = pw_master_abort;
    ev_raw[ber_pkg::EV_PW_RETRY] = retry_hit[0];
    ev_raw[ber_pkg::EV_DW_RETRY] = retry_hit[1];
    ev_raw[ber_pkg::EV_DR_RETRY] = retry_hit[2];
    ev_raw[ber_pkg::EV_MTIMEOUT] = dt_master_timeout;
  end

  // per-event gates; command enable gates everything
  always_comb begin
    ev_qual = ev_raw & ~(st_reg.evdis & ber_pkg::DIS_MASK);
    ev_qual[ber_pkg::EV_PARITY] = ev_qual[ber_pkg::EV_PARITY] &
      st_reg.cmd[ber_pkg::CMD_PAR_RESP] & st_reg.bctl[ber_pkg::BCTL_PAR_RESP];
    ev_qual[ber_pkg::EV_FORWARD] = ev_raw[ber_pkg::EV_FORWARD] &
      st_reg.bctl[ber_pkg::BCTL_SERR_FWD];
    ev_qual[ber_pkg::EV_MTIMEOUT] = ev_raw[ber_pkg::EV_MTIMEOUT] &
      st_reg.bctl[ber_pkg::BCTL_MTO_SERR];
    if (!st_reg.cmd[ber_pkg::CMD_SERR_EN]) begin
      ev_qual = 8'h00;
    end
  end

  // secondary parity drive request
  assign perr_trig = st_reg.bctl[ber_pkg::BCTL_PAR_RESP] &
    ((sec_data_parity_err & (sec_write_target | sec_read_initiator)) |
     (up_dw_completion & ~st_reg.pperr_smp & st_reg.cmd[ber_pkg::CMD_PAR_RESP]));

  assign wr_fire   = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid;
  assign clr_cause = wr_fire & st_reg.w_strb[0] &
    ({st_reg.aw_addr[ADDR_W-1:2], 2'b00} == ADDR_W'(ber_pkg::OFF_CAUSE));

  // next state of the whole block
  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [7:0]        wb;
    st_next = st_reg;
    wa      = {st_reg.aw_addr[ADDR_W-1:2], 2'b00};
    ra      = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wb      = st_reg.w_data[7:0];

    // two-stage synchronisers, then bus clock edge samples
    st_next.sync1     = {downstream_side_system_err_n, downstream_side_parity_err_n_in,
                         upstream_side_parity_err_n, downstream_side_clk, upstream_side_clk};
    st_next.sync2     = st_reg.sync1;
    st_next.lclk_prev = {st_reg.sync2[ber_pkg::PIN_SCLK], st_reg.sync2[ber_pkg::PIN_PCLK]};
    if (pclk_rise) begin
      st_next.pperr_smp = st_reg.sync2[ber_pkg::PIN_PPERR];
    end
    if (sclk_rise) begin
      st_next.sperr_smp = st_reg.sync2[ber_pkg::PIN_SPERR];
      st_next.sserr_smp = st_reg.sync2[ber_pkg::PIN_SSERR];
    end

    // retry counters: delivery restarts, limit discards and restarts
    for (int i = 0; i < 3; i++) begin
      st_next.discard[i] = retry_hit[i];
      if (delivered[i] || retry_hit[i]) begin
        st_next.retry_cnt[i] = '0;
      end else if (retry_rcvd[i]) begin
        st_next.retry_cnt[i] = st_reg.retry_cnt[i] + RW'(1);
      end
    end

    // system error pulse: one bus period low, retriggered by new causes
    if (ev_qual != 8'h00) begin
      st_next.serr_oe_n = 1'b0;
      st_next.serr_cnt  = LINK_CNT;
    end else if (st_reg.serr_cnt != 4'h0) begin
      st_next.serr_cnt = st_reg.serr_cnt - 4'h1;
      if (st_reg.serr_cnt == 4'h1) begin
        st_next.serr_oe_n = 1'b1;
      end
    end

    // parity output: drive low, drive high a period, then let go
    case (st_reg.pe_state)
      ber_pkg::BER_PE_IDLE: begin
        if (perr_trig) begin
          st_next.pe_state = ber_pkg::BER_PE_LOW;
          st_next.pe_oe_n  = 1'b0;
          st_next.pe_out   = 1'b0;
          st_next.pe_cnt   = LINK_CNT;
        end
      end
      ber_pkg::BER_PE_LOW: begin
        st_next.pe_cnt = st_reg.pe_cnt - 4'h1;
        if (st_reg.pe_cnt == 4'h1) begin
          st_next.pe_state = ber_pkg::BER_PE_HIGH;
          st_next.pe_out   = 1'b1;
          st_next.pe_cnt   = LINK_CNT;
        end
      end
      ber_pkg::BER_PE_HIGH: begin
        st_next.pe_cnt = st_reg.pe_cnt - 4'h1;
        if (st_reg.pe_cnt == 4'h1) begin
          st_next.pe_state = ber_pkg::BER_PE_IDLE;
          st_next.pe_oe_n  = 1'b1;
        end
      end
      default: begin
        st_next.pe_state = ber_pkg::BER_PE_IDLE;
        st_next.pe_oe_n  = 1'b1;
        st_next.pe_out   = 1'b1;
      end
    endcase

    // locks: each side on its own, crossing lock holds both
    if (cross_lock_set) begin
      st_next.cross_lock = 1'b1;
    end else if (cross_lock_clr) begin
      st_next.cross_lock = 1'b0;
    end
    if (pri_lock_set) begin
      st_next.pri_lock = 1'b1;
    end else if (pri_lock_clr) begin
      st_next.pri_lock = 1'b0;
    end
    if (sec_lock_set) begin
      st_next.sec_lock = 1'b1;
    end else if (sec_lock_clr) begin
      st_next.sec_lock = 1'b0;
    end
    // held flags registered so the outputs come straight from flops
    st_next.pri_held = st_next.pri_lock | st_next.cross_lock;
    st_next.sec_held = st_next.sec_lock | st_next.cross_lock;

    // axi write channels taken independently, one write at a time
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end
    if (wr_fire) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = ber_pkg::RESP_OKAY;
      // only the low lane holds fields; w1c bits clear on written ones
      case (wa)
        ADDR_W'(ber_pkg::OFF_CMD): begin
          if (st_reg.w_strb[0]) st_next.cmd = wb[1:0];
        end
        ADDR_W'(ber_pkg::OFF_STATUS): begin
          if (st_reg.w_strb[0] && wb[ber_pkg::STS_SIG_SERR]) st_next.sig_serr = 1'b0;
        end
        ADDR_W'(ber_pkg::OFF_BCTL): begin
          if (st_reg.w_strb[0]) st_next.bctl = wb[2:0];
        end
        ADDR_W'(ber_pkg::OFF_SSTATUS): begin
          if (st_reg.w_strb[0] && wb[ber_pkg::SSTS_RCV_SERR]) st_next.rcv_serr = 1'b0;
        end
        ADDR_W'(ber_pkg::OFF_CAUSE): begin
          if (st_reg.w_strb[0]) st_next.cause = st_reg.cause & ~wb;
        end
        ADDR_W'(ber_pkg::OFF_DISABLE): begin
          if (st_reg.w_strb[0]) st_next.evdis = wb & ber_pkg::DIS_MASK;
        end
        default: st_next.bresp = ber_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid  = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready  = 1'b1;
    end

    // sticky status: hardware set wins over a clear in the same cycle
    if (ev_qual != 8'h00) begin
      st_next.sig_serr = 1'b1;
    end
    if (sserr_event) begin
      st_next.rcv_serr = 1'b1;
    end
    st_next.cause = st_next.cause | ev_qual;

    // axi read: one outstanding, data from registers
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid  = 1'b1;
      st_next.rresp   = ber_pkg::RESP_OKAY;
      st_next.rdata   = 32'h0000_0000;
      case (ra)
        ADDR_W'(ber_pkg::OFF_CMD):     st_next.rdata[1:0] = st_reg.cmd;
        ADDR_W'(ber_pkg::OFF_STATUS):  st_next.rdata[0]   = st_reg.sig_serr;
        ADDR_W'(ber_pkg::OFF_BCTL):    st_next.rdata[2:0] = st_reg.bctl;
        ADDR_W'(ber_pkg::OFF_SSTATUS): st_next.rdata[0]   = st_reg.rcv_serr;
        ADDR_W'(ber_pkg::OFF_CAUSE):   st_next.rdata[7:0] = st_reg.cause;
        ADDR_W'(ber_pkg::OFF_DISABLE): st_next.rdata[7:0] = st_reg.evdis;
        default:                       st_next.rresp      = ber_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid  = 1'b0;
      st_next.arready = 1'b1;
    end
  end

  // one register stage for all state; pins idle released and high
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_reg           <= '0;
      st_reg.sync1     <= 5'h1F;
      st_reg.sync2     <= 5'h1F;
      st_reg.lclk_prev <= 2'h3;
      st_reg.pperr_smp <= 1'b1;
      st_reg.sperr_smp <= 1'b1;
      st_reg.sserr_smp <= 1'b1;
      st_reg.cmd       <= ber_pkg::CMD_RST;
      st_reg.bctl      <= ber_pkg::BCTL_RST;
      st_reg.evdis     <= ber_pkg::DIS_RST;
      st_reg.serr_oe_n <= 1'b1;
      st_reg.pe_state  <= ber_pkg::BER_PE_IDLE;
      st_reg.pe_out    <= 1'b1;
      st_reg.pe_oe_n   <= 1'b1;
      st_reg.awready   <= 1'b1;
      st_reg.wready    <= 1'b1;
      st_reg.arready   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register; system error data output tied low
  assign upstream_side_system_err_n_out    = 1'b0;
  assign upstream_side_system_err_n_oe_n   = st_reg.serr_oe_n;
  assign downstream_side_parity_err_n_out  = st_reg.pe_out;
  assign downstream_side_parity_err_n_oe_n = st_reg.pe_oe_n;
  assign retry_discard  = st_reg.discard;
  assign pri_lock_held  = st_reg.pri_held;
  assign sec_lock_held  = st_reg.sec_held;
  assign s_axi_awready  = st_reg.awready;
  assign s_axi_wready   = st_reg.wready;
  assign s_axi_bvalid   = st_reg.bvalid;
  assign s_axi_bresp    = st_reg.bresp;
  assign s_axi_arready  = st_reg.arready;
  assign s_axi_rvalid   = st_reg.rvalid;
  assign s_axi_rdata    = st_reg.rdata;
  assign s_axi_rresp    = st_reg.rresp;

  // checks on the error outputs, status and cause bits, and lock independence
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_serr_low;
    !st_reg.serr_oe_n [*8];
  endsequence

  sequence s_perr_pulse;
    (!st_reg.pe_oe_n && !st_reg.pe_out) [*8] ##1
    (!st_reg.pe_oe_n && st_reg.pe_out) [*8] ##1 st_reg.pe_oe_n;
  endsequence

  a_serr_needs_enable: assert property ($fell(st_reg.serr_oe_n) |->
    $past(st_reg.cmd[ber_pkg::CMD_SERR_EN])) else $error("system error without enable");

  a_serr_sets_status: assert property ($fell(st_reg.serr_oe_n) |-> st_reg.sig_serr)
    else $error("signaled status not set");

  a_serr_pulse_len: assert property ($fell(st_reg.serr_oe_n) |-> s_serr_low)
    else $error("system error pulse too short");

  a_forward_serr: assert property ((sserr_event && st_reg.cmd[ber_pkg::CMD_SERR_EN] &&
    st_reg.bctl[ber_pkg::BCTL_SERR_FWD]) |=> !st_reg.serr_oe_n && st_reg.cause[1])
    else $error("secondary system error not forwarded");

  a_rcv_serr_set: assert property (sserr_event |=> st_reg.rcv_serr)
    else $error("received system error not recorded");

  a_parity_both_bits: assert property ($rose(st_reg.cause[0]) |->
    $past(st_reg.cmd[ber_pkg::CMD_PAR_RESP] && st_reg.bctl[ber_pkg::BCTL_PAR_RESP]))
    else $error("parity system error without both response bits");

  a_parity_self_none: assert property (pw_self_detected |-> !ev_qual[0])
    else $error("self detected parity raised system error");

  a_mto_no_disable: assert property ((dt_master_timeout &&
    st_reg.cmd[ber_pkg::CMD_SERR_EN] && st_reg.bctl[ber_pkg::BCTL_MTO_SERR])
    |=> st_reg.cause[7] && !st_reg.serr_oe_n) else $error("master timeout not reported");

  a_disabled_event: assert property ((pw_target_abort && st_reg.evdis[2] &&
    !st_reg.cause[2]) |=> !st_reg.cause[2]) else $error("disabled event recorded");

  a_cause_sticky: assert property ((st_reg.cause != 8'h00 && !clr_cause) |=>
    ((st_reg.cause & $past(st_reg.cause)) == $past(st_reg.cause)))
    else $error("cause bit lost without software clear");

  a_perr_drive: assert property ((perr_trig && st_reg.pe_state == ber_pkg::BER_PE_IDLE)
    |=> s_perr_pulse) else $error("parity output sequence wrong");

  a_lock_indep: assert property ((sec_lock_set && !pri_lock_set && !pri_lock_clr &&
    !cross_lock_set && !cross_lock_clr) |=> $stable(pri_lock_held))
    else $error("secondary lock disturbed primary lock");

endmodule

// ==== ber_error_report_tb.sv ====
// self-checking bench for the bridge error reporting block
module ber_error_report_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'h0, resetn = 1'h0, req = 1'h0, kind = 1'h0, hit, spar_n, plk, slk;
  logic        busy, pclk, sclk, ppar_n, sserr_n, serr_out, serr_oe_n, spar_out, spar_oe_n;
  logic [21:0] st = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [2:0]  retry_discard;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  ber_error_report #(.RETRY_LIMIT(4)) dut (.*,
    .upstream_side_clk(pclk), .downstream_side_clk(sclk), .upstream_side_parity_err_n(ppar_n),
    .upstream_side_system_err_n_out(serr_out), .upstream_side_system_err_n_oe_n(serr_oe_n),
    .downstream_side_parity_err_n_in(spar_n & (spar_oe_n | spar_out)),
    .downstream_side_parity_err_n_out(spar_out), .downstream_side_parity_err_n_oe_n(spar_oe_n),
    .downstream_side_system_err_n(sserr_n), .sec_data_parity_err(st[0]),
    .sec_write_target(st[1]), .sec_read_initiator(st[2]), .up_dw_completion(st[3]),
    .pw_down_active(st[4]), .pw_up_active(st[5]), .pw_self_detected(st[6]),
    .pw_target_abort(st[7]), .pw_master_abort(st[8]), .dt_master_timeout(st[9]),
    .retry_rcvd(st[12:10]), .delivered(st[15:13]), .pri_lock_set(st[16]),
    .pri_lock_clr(st[17]), .sec_lock_set(st[18]), .sec_lock_clr(st[19]),
    .cross_lock_set(st[20]), .cross_lock_clr(st[21]), .pri_lock_held(plk), .sec_lock_held(slk),
    .s_axi_wstrb(4'hF));
  ber_bus_model far (.req(req), .kind(kind), .busy(busy), .pclk(pclk), .sclk(sclk),
    .ppar_n(ppar_n), .spar_n(spar_n), .sserr_n(sserr_n));
  // 40 mhz block clock
  always #12.5 mclk = ~mclk;
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // one-cycle event pulse, returns once its registered effect has landed
  task automatic pulse(input int i);
    @(posedge mclk);
    st[i] <= 1'h1;
    @(posedge mclk);
    st[i] <= 1'h0;
    @(negedge mclk);
  endtask
  // discard pulse may land this cycle or the next two
  task automatic win(output logic h);
    h = retry_discard[0];
    repeat (2) @(negedge mclk) h |= retry_discard[0];
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'h1;
    repeat (3) @(posedge mclk);
    rd(8'h18, d);
    chk({30'h0, resp}, 32'h2);
    pulse(7);
    chk(32'(serr_oe_n), 32'h1);
    wr(ber_pkg::OFF_CMD, 32'h2);
    pulse(7);
    chk(32'(serr_oe_n), 32'h0);
    repeat (12) @(posedge mclk);
    rd(ber_pkg::OFF_CAUSE, d);
    chk(d, 32'h4);
    rd(ber_pkg::OFF_STATUS, d);
    chk(d, 32'h1);
    $display("test abort done");
    wr(ber_pkg::OFF_CAUSE, 32'hFF);
    wr(ber_pkg::OFF_DISABLE, 32'hC);
    pulse(8);
    chk(32'(serr_oe_n), 32'h1);
    pulse(7);
    chk(32'(serr_oe_n), 32'h1);
    pulse(9);
    chk(32'(serr_oe_n), 32'h1);
    $display("test masking done");
    repeat (3) pulse(10);
    win(hit);
    chk(32'(hit), 32'h0);
    pulse(10);
    win(hit);
    chk(32'(hit), 32'h1);
    rd(ber_pkg::OFF_CAUSE, d);
    chk(d, 32'h10);
    $display("test retry done");
    wr(ber_pkg::OFF_CMD, 32'h3);
    wr(ber_pkg::OFF_BCTL, 32'h7);
    pulse(9);
    chk(32'(serr_oe_n), 32'h0);
    // odd frames: up only, down only, up but self detected
    for (int k = 0; k < 6; k++) begin
      wr(ber_pkg::OFF_CAUSE, 32'hFF);
      kind <= k[0];
      st[6:4] <= (k == 1) ? 3'h2 : (k == 3) ? 3'h1 : (k == 5) ? 3'h6 : 3'h0;
      req <= 1'h1;
      @(posedge busy);
      @(negedge busy);
      req <= 1'h0;
      repeat (6) @(posedge mclk);
      st[6:4] <= 3'h0;
      rd(ber_pkg::OFF_CAUSE, d);
      chk(d, k[0] ? {31'h0, k != 5} : 32'h2);
    end
    rd(ber_pkg::OFF_SSTATUS, d);
    chk(d, 32'h1);
    $display("test pins done");
    st[1] <= 1'h1;
    pulse(0);
    chk({30'h0, spar_oe_n, spar_out}, 32'h0);
    repeat (8) @(negedge mclk);
    chk({30'h0, spar_oe_n, spar_out}, 32'h1);
    repeat (9) @(posedge mclk);
    st[1] <= 1'h0;
    pulse(0);
    chk({30'h0, spar_oe_n, spar_out}, 32'h3);
    pulse(16);
    pulse(18);
    chk({30'h0, plk, slk}, 32'h3);
    pulse(19);
    chk({30'h0, plk, slk}, 32'h2);
    $display("test drive and lock done");
    wrap_up();
  end
endmodule

// ==== ber_pkg.sv ====
// constants, register map and field layout for the bridge error reporting block
// Operation
// - secondary parity output only when enabled target/initiator
// - primary parity seen on upstream delayed write completion
// - forwarded posted write target parity raises system error
// - no system error for self-detected target parity
// - parity system error needs both response bits
// - downstream posted write: secondary seen, primary not
// - upstream posted write: primary seen, secondary not
// - system error output needs command enable bit
// - every assertion sets signaled system error status
// - forward secondary system error when forward enabled
// - secondary system error sets received status bit
// - target abort on posted write raises error
// - master abort on posted write raises error
// - posted write discarded after retry limit
// - delayed write discarded after retry limit
// - delayed read fails after retry limit
// - delayed transaction master timeout raises error
// - cause register records which event asserted
// - per-event disable bits suppress system error
// - master timeout gated only by bridge control
// - both bus locks independent unless lock crosses
package ber_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_BCTL     = 8'h08;
  localparam logic [7:0] OFF_SSTATUS  = 8'h0C;
  localparam logic [7:0] OFF_CAUSE    = 8'h10;
  localparam logic [7:0] OFF_DISABLE  = 8'h14;

  // command register fields
  localparam int CMD_PAR_RESP   = 0;
  localparam int CMD_SERR_EN    = 1;
  // status register fields
  localparam int STS_SIG_SERR   = 0;
  // bridge control fields
  localparam int BCTL_PAR_RESP  = 0;
  localparam int BCTL_SERR_FWD  = 1;
  localparam int BCTL_MTO_SERR  = 2;
  // secondary status fields
  localparam int SSTS_RCV_SERR  = 0;

  // event / cause bit positions
  localparam int EV_PARITY   = 0;
  localparam int EV_FORWARD  = 1;
  localparam int EV_TABORT   = 2;
  localparam int EV_MABORT   = 3;
  localparam int EV_PW_RETRY = 4;
  localparam int EV_DW_RETRY = 5;
  localparam int EV_DR_RETRY = 6;
  localparam int EV_MTIMEOUT = 7;
  localparam int EV_NUM      = 8;

  // disable bits exist for every event except forward and master timeout
  localparam logic [7:0] DIS_MASK = 8'h7D;

  // reset values
  localparam logic [1:0] CMD_RST  = 2'h0;
  localparam logic [2:0] BCTL_RST = 3'h0;
  localparam logic [7:0] DIS_RST  = 8'h00;

  // sync input bit positions
  localparam int PIN_PCLK  = 0;
  localparam int PIN_SCLK  = 1;
  localparam int PIN_PPERR = 2;
  localparam int PIN_SPERR = 3;
  localparam int PIN_SSERR = 4;

  // timing: error pulses last one bus clock period
  localparam int MCLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_CYC       = (LINK_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // retry limit default
  localparam int RETRY_LIMIT_DEF = 2 ** 24;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // parity drive sequencer
  typedef enum logic [2:0] {
    BER_PE_IDLE = 3'b001,
    BER_PE_LOW  = 3'b010,
    BER_PE_HIGH = 3'b100
  } ber_pe_state_t;

endpackage
